// ---- hdl/tsh_pkg.sv ----
// Constants and types for the two-wire slave port with hold and 10-bit addressing
package tsh_pkg;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  localparam int PIN_COUNT = 2;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_TX,
    ST_ACK,
    ST_ACKIN
  } tsh_state_type;
endpackage

// ---- hdl/tsh_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module tsh_pin_sync #(
  parameter int WIDTH = tsh_pkg::PIN_COUNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinStable
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      logic [2:0] stage_reg;
      logic stable_reg;
      // Shift chain; the output moves only when stages two and three agree
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stage_reg <= tsh_pkg::SYNC_IDLE;
          stable_reg <= 1'b1;
        end else if (ce) begin
          stage_reg <= {stage_reg[1:0], pinIn[i]};
          if (stage_reg[1] == stage_reg[2]) begin
            stable_reg <= stage_reg[2];
          end
        end
      end
      // Agreeing stages pass straight through, so a line edge is seen a cycle sooner
      assign pinStable[i] = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : stable_reg;
    end
  endgenerate
endmodule // tsh_pin_sync

// ---- hdl/tsh_slave.sv ----
// Two-wire slave port: address/data hold, 10-bit addressing, clock stretching
`timescale 1ns/100ps
module tsh_slave #(
  parameter logic [7:0] ADDR_RESET = tsh_pkg::ADDR_RESET
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic tenBitMode,
  input wire logic addrHoldEnable,
  input wire logic dataHoldEnable,
  input wire logic stretchEnable,
  input wire logic startIrqEnable,
  input wire logic ackDataValue,
  input wire logic clockReleaseSet,
  input wire logic irqFlagClear,
  input wire logic txWrite,
  input wire logic [7:0] txData,
  input wire logic rxRead,
  input wire logic addrWrite,
  input wire logic [7:0] addrWriteData,
  output logic portIrqFlag,
  output logic clockRelease,
  output logic bufferFull,
  output logic ackReceivedStatus,
  output logic ackTimingStatus,
  output logic readWriteStatus,
  output logic dataAddressStatus,
  output logic startDetected,
  output logic stopDetected,
  output logic updateAddressFlag,
  output logic [7:0] rxData,
  output logic [7:0] slaveAddress
);
  tsh_pkg::tsh_state_type state_reg;
  logic [1:0] pinState;
  logic sclF, sdaF, sclPrev_reg, sdaPrev_reg;
  logic sclRise, sclFall, startEvt, stopEvt;
  logic inIdle, inAddr, inRx, inTx, inAck, inAckIn;
  logic byteDone, ackEnd, rwBit, addrMatch, ackNow;
  logic holdAddr, holdData, lowMiss, ackIrq, stretchAck;
  logic clearEvt, irqSet, bufSet, uaSet, holdReq;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg, txShift_reg, rxData_reg, addr_reg;
  logic lowPhase_reg, tenAddressed_reg, rw_reg, held_reg, ackOk_reg;
  logic sclOe_reg, sdaOe_reg, lineLow_reg;
  logic irqFlag_reg, clockRelease_reg, bufferFull_reg, ua_reg;
  logic ackReceived_reg, ackTiming_reg, dataAddr_reg;
  logic startDet_reg, stopDet_reg;

  // Bus lines pass the three-stage filter
  tsh_pin_sync #(
    .WIDTH(tsh_pkg::PIN_COUNT)
  ) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pinIn({sclIn, sdaIn}),
    .pinStable(pinState)
  );
  assign sclF = pinState[1];
  assign sdaF = pinState[0];

  // Previous line levels for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else if (ce) begin
      sclPrev_reg <= sclF;
      sdaPrev_reg <= sdaF;
    end
  end

  // Line edges and bus conditions
  assign sclRise = sclF & ~sclPrev_reg;
  assign sclFall = ~sclF & sclPrev_reg;
  assign startEvt = sclF & sclPrev_reg & ~sdaF & sdaPrev_reg;
  assign stopEvt = sclF & sclPrev_reg & sdaF & ~sdaPrev_reg;

  // State decode
  assign inIdle = state_reg == tsh_pkg::ST_IDLE;
  assign inAddr = state_reg == tsh_pkg::ST_ADDR;
  assign inRx = state_reg == tsh_pkg::ST_RX;
  assign inTx = state_reg == tsh_pkg::ST_TX;
  assign inAck = state_reg == tsh_pkg::ST_ACK;
  assign inAckIn = state_reg == tsh_pkg::ST_ACKIN;

  // Byte end at the 8th falling edge, acknowledge end at the 9th
  assign byteDone = sclFall & (bitCnt_reg == tsh_pkg::BYTE_BITS) & (inAddr | inRx | inTx);
  assign ackEnd = sclFall & (bitCnt_reg == tsh_pkg::ACK_BIT) & (inAck | inAckIn);

  // Address compare; a 10-bit read needs a prior full match
  assign rwBit = shift_reg[0];
  assign addrMatch = lowPhase_reg ? (shift_reg == addr_reg) :
    ((shift_reg[7:1] == addr_reg[7:1]) & (~tenBitMode | ~rwBit | tenAddressed_reg));

  // Acknowledge to drive at byte end; a held byte uses the software value
  assign ackNow = inAddr ? (addrMatch & (~addrHoldEnable | ~ackDataValue)) :
    (~dataHoldEnable | ~ackDataValue);

  // Hardware events on the release bit, the interrupt flag, buffer full, the update-address flag and the clock hold
  assign holdAddr = byteDone & inAddr & addrMatch & addrHoldEnable;
  assign holdData = byteDone & inRx & dataHoldEnable;
  assign lowMiss = byteDone & inAddr & lowPhase_reg & ~addrMatch;
  assign ackIrq = ackEnd & ((inAck & sdaOe_reg) | inAckIn);
  assign stretchAck = ackEnd & ((inAck & sdaOe_reg & (rw_reg | stretchEnable)) |
    (inAckIn & ~ackReceived_reg));
  assign clearEvt = holdAddr | holdData | stretchAck;
  assign irqSet = (startEvt & startIrqEnable) | holdAddr | holdData | lowMiss | ackIrq;
  assign bufSet = (byteDone & ((inAddr & addrMatch) | inRx)) | txWrite;
  assign uaSet = byteDone & inAddr & tenBitMode & (lowPhase_reg | (~rwBit & addrMatch & ~tenAddressed_reg));
  assign holdReq = ~clockRelease_reg | (ua_reg & ~inAck);

  // Bit counter, cleared by Start and at each acknowledge end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitCnt_reg <= tsh_pkg::CNT_ZERO;
    end else if (ce) begin
      if (startEvt | ackEnd) begin
        bitCnt_reg <= tsh_pkg::CNT_ZERO;
      end else if (sclRise & ~inIdle) begin
        bitCnt_reg <= bitCnt_reg + tsh_pkg::CNT_STEP;
      end
    end
  end

  // Receive shifter, sampled on rising edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_reg <= 8'h00;
    end else if (ce && sclRise && (inAddr || inRx)) begin
      shift_reg <= {shift_reg[6:0], sdaF};
    end
  end

  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= tsh_pkg::ST_IDLE;
      lowPhase_reg <= 1'b0;
      tenAddressed_reg <= 1'b0;
      rw_reg <= 1'b0;
      held_reg <= 1'b0;
      ackOk_reg <= 1'b0;
    end else if (ce) begin
      if (stopEvt) begin
        state_reg <= tsh_pkg::ST_IDLE;
        lowPhase_reg <= 1'b0;
        tenAddressed_reg <= 1'b0;
      end else if (startEvt) begin
        state_reg <= tsh_pkg::ST_ADDR;
        lowPhase_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          tsh_pkg::ST_IDLE: begin
            state_reg <= tsh_pkg::ST_IDLE;
          end
          tsh_pkg::ST_ADDR: begin
            if (byteDone) begin
              state_reg <= tsh_pkg::ST_ACK;
              ackOk_reg <= addrMatch;
              held_reg <= addrHoldEnable & addrMatch;
              if (!lowPhase_reg) begin
                rw_reg <= rwBit;
              end
              if (lowPhase_reg && addrMatch) begin
                tenAddressed_reg <= 1'b1;
              end
            end
          end
          tsh_pkg::ST_RX: begin
            if (byteDone) begin
              state_reg <= tsh_pkg::ST_ACK;
              ackOk_reg <= 1'b1;
              held_reg <= dataHoldEnable;
            end
          end
          tsh_pkg::ST_TX: begin
            if (byteDone) begin
              state_reg <= tsh_pkg::ST_ACKIN;
            end
          end
          tsh_pkg::ST_ACK: begin
            if (ackEnd) begin
              if (!sdaOe_reg) begin
                state_reg <= tsh_pkg::ST_IDLE;
              end else if (rw_reg) begin
                state_reg <= tsh_pkg::ST_TX;
              end else if (!dataAddr_reg && tenBitMode && !lowPhase_reg && !tenAddressed_reg) begin
                state_reg <= tsh_pkg::ST_ADDR;
                lowPhase_reg <= 1'b1;
              end else begin
                state_reg <= tsh_pkg::ST_RX;
              end
            end
          end
          tsh_pkg::ST_ACKIN: begin
            if (ackEnd) begin
              // Not-acknowledge from the master ends the read
              state_reg <= ackReceived_reg ? tsh_pkg::ST_IDLE : tsh_pkg::ST_TX;
            end
          end
        endcase
      end
    end
  end

  // Data line drive: acknowledge slot and transmit bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdaOe_reg <= 1'b0;
    end else if (ce) begin
      if (startEvt || stopEvt) begin
        sdaOe_reg <= 1'b0;
      end else if (ackEnd) begin
        sdaOe_reg <= (inAck ? (sdaOe_reg & rw_reg) : ~ackReceived_reg) & ~txShift_reg[7];
      end else if (byteDone) begin
        sdaOe_reg <= (inAddr | inRx) & ackNow;
      end else if (inAck && !sclF && held_reg) begin
        sdaOe_reg <= ackOk_reg & ~ackDataValue;
      end else if (inTx && sclFall) begin
        sdaOe_reg <= ~txShift_reg[6];
      end else if (inTx && txWrite && bitCnt_reg == tsh_pkg::CNT_ZERO) begin
        sdaOe_reg <= ~txData[7];
      end
    end
  end

  // Transmit shifter, loaded by software, moved on falling edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txShift_reg <= 8'hFF;
    end else if (ce) begin
      if (txWrite) begin
        txShift_reg <= txData;
      end else if (inTx && sclFall && !byteDone) begin
        txShift_reg <= {txShift_reg[6:0], 1'b1};
      end
    end
  end

  // Clock hold waits for the line to be low, then keeps it low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclOe_reg <= 1'b0;
      lineLow_reg <= 1'b0;
    end else if (ce) begin
      sclOe_reg <= holdReq & (sclOe_reg | ~sclF);
      lineLow_reg <= 1'b0;
    end
  end

  // Clock release bit: hardware clear wins over software set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clockRelease_reg <= 1'b1;
    end else if (ce) begin
      if (clearEvt) begin
        clockRelease_reg <= 1'b0;
      end else if (clockReleaseSet) begin
        clockRelease_reg <= 1'b1;
      end
    end
  end

  // Interrupt flag: set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqFlag_reg <= 1'b0;
    end else if (ce) begin
      if (irqSet) begin
        irqFlag_reg <= 1'b1;
      end else if (irqFlagClear) begin
        irqFlag_reg <= 1'b0;
      end
    end
  end

  // Buffer full and receive data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bufferFull_reg <= 1'b0;
      rxData_reg <= 8'h00;
    end else if (ce) begin
      if (bufSet) begin
        bufferFull_reg <= 1'b1;
      end else if (rxRead || (byteDone && inTx)) begin
        bufferFull_reg <= 1'b0;
      end
      if (byteDone && ((inAddr && addrMatch) || inRx)) begin
        rxData_reg <= shift_reg;
      end
    end
  end

  // Update-address flag and address register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ua_reg <= 1'b0;
      addr_reg <= ADDR_RESET;
    end else if (ce) begin
      if (uaSet) begin
        ua_reg <= 1'b1;
      end else if (addrWrite) begin
        ua_reg <= 1'b0;
      end
      if (addrWrite) begin
        addr_reg <= addrWriteData;
      end
    end
  end

  // Master acknowledge capture on the 9th rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackReceived_reg <= 1'b0;
    end else if (ce && sclRise && inAckIn) begin
      ackReceived_reg <= sdaF;
    end
  end

  // Status bits for interrupt source decoding
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackTiming_reg <= 1'b0;
      dataAddr_reg <= 1'b0;
    end else if (ce) begin
      if (startEvt || stopEvt || ackEnd) begin
        ackTiming_reg <= 1'b0;
      end else if (byteDone && (inAddr || inRx)) begin
        ackTiming_reg <= 1'b1;
      end
      if (startEvt || (byteDone && inAddr)) begin
        dataAddr_reg <= 1'b0;
      end else if (byteDone && (inRx || inTx)) begin
        dataAddr_reg <= 1'b1;
      end
    end
  end

  // Start and Stop status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startDet_reg <= 1'b0;
      stopDet_reg <= 1'b0;
    end else if (ce) begin
      if (startEvt) begin
        startDet_reg <= 1'b1;
        stopDet_reg <= 1'b0;
      end else if (stopEvt) begin
        startDet_reg <= 1'b0;
        stopDet_reg <= 1'b1;
      end
    end
  end

  // Outputs straight from flops; pins only ever pull low
  assign sclOut = lineLow_reg;
  assign sdaOut = lineLow_reg;
  assign sclOe = sclOe_reg;
  assign sdaOe = sdaOe_reg;
  assign portIrqFlag = irqFlag_reg;
  assign clockRelease = clockRelease_reg;
  assign bufferFull = bufferFull_reg;
  assign ackReceivedStatus = ackReceived_reg;
  assign ackTimingStatus = ackTiming_reg;
  assign readWriteStatus = rw_reg;
  assign dataAddressStatus = dataAddr_reg;
  assign startDetected = startDet_reg;
  assign stopDetected = stopDet_reg;
  assign updateAddressFlag = ua_reg;
  assign rxData = rxData_reg;
  assign slaveAddress = addr_reg;

  // Checks on the stretching and status behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_hold_after_low: assert property ($rose(sclOe_reg) |-> !$past(sclF))
    else $error("Clock driven low before line was low");
  a_release_on_set: assert property (ce && clockRelease_reg && !ua_reg |=> !sclOe_reg)
    else $error("Clock not released");
  a_ua_release: assert property (ce && addrWrite && !uaSet && clockRelease_reg && !clearEvt
    |=> !ua_reg ##1 (!sclOe_reg || !$past(ce)))
    else $error("Address write did not release clock");
  a_addr_hold: assert property (ce && holdAddr |=> !clockRelease_reg && irqFlag_reg)
    else $error("Address hold missing");
  a_read_stretch: assert property (ce && ackEnd && inAck && sdaOe_reg && rw_reg
    |=> !clockRelease_reg && state_reg == tsh_pkg::ST_TX)
    else $error("Read did not stretch");
  a_ack_value: assert property (ce && inAck && held_reg && !sclF && !ackEnd && !startEvt && !stopEvt
    |=> sdaOe_reg == (ackOk_reg && !$past(ackDataValue)))
    else $error("Wrong acknowledge value");
  a_ack_capture: assert property (ce && sclRise && inAckIn |=> ackReceived_reg == $past(sdaF))
    else $error("Master acknowledge not captured");
  a_start_irq: assert property (ce && startEvt && startIrqEnable |=> irqFlag_reg && startDet_reg)
    else $error("Start not flagged");
  a_buf_write: assert property (ce && txWrite |=> bufferFull_reg)
    else $error("Buffer full not set");
  a_rx_clear: assert property (ce && rxRead && !bufSet && !(byteDone && inTx) ##1 1'b1
    |-> !bufferFull_reg)
    else $error("Buffer full not cleared");
endmodule // tsh_slave

// ---- verif/tsh_bus_master.sv ----
// Behavioural two-wire bus master that drives and samples the shared lines
`timescale 1ns/100ps
module tsh_bus_master (
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclLow,
  output logic sdaLow,
  output int fails
);
  // Both lines released at power-up
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    fails = 0;
  end

  // Release the clock and wait, bounded, while the slave stretches it
  task automatic riseScl();
    int n;
    n = 0;
    sclLow = 1'b0;
    while (sclLine !== 1'b1 && n < 2000) begin
      #10;
      n++;
    end
    if (n >= 2000) fails++;
    #50;
  endtask

  // One clock pulse: 125 ns low so the slave can settle its data, 75 ns high
  task automatic bitXfer(input logic b, output logic s);
    #50;
    sdaLow = ~b;
    #75;
    riseScl();
    s = sdaLine;
    #25;
    sclLow = 1'b1;
  endtask

  // Eight bits out, most significant first
  task automatic sendByte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitXfer(d[i], s);
  endtask

  // Eight bits in with the data line released
  task automatic getByte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitXfer(1'b1, d[i]);
  endtask

  // Start or repeated start; ends with the clock held low
  task automatic busStart();
    sdaLow = 1'b0;
    #50;
    riseScl();
    #50;
    sdaLow = 1'b1;
    #100;
    sclLow = 1'b1;
  endtask

  // Stop: data rises while the clock is high
  task automatic busStop();
    #50;
    sdaLow = 1'b1;
    #50;
    riseScl();
    #50;
    sdaLow = 1'b0;
    #100;
  endtask
endmodule // tsh_bus_master

// ---- verif/test_tsh_slave.sv ----
// Self-checking bench for the two-wire slave port with hold and 10-bit addressing
`timescale 1ns/100ps
module test_tsh_slave;
  localparam logic [7:0] OWN_ADDR = 8'h52;
  logic clk;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [5:0] cfg = 6'h00;
  logic [4:0] swStrobe = 5'h00;
  logic [7:0] swData = 8'h00;
  logic sclOut, sclOe, sdaOut, sdaOe, portIrqFlag, clockRelease, bufferFull, ackReceivedStatus;
  logic ackTimingStatus, readWriteStatus, dataAddressStatus, startDetected, stopDetected, updateAddressFlag;
  logic [7:0] rxData;
  logic [7:0] slaveAddress;
  logic [7:0] stat;
  logic [7:0] rdByte;
  logic mSclLow, mSdaLow, ackBit;
  int mFails;
  int numErrors = 0;
  int testsRun = 0;
  wire logic sclLine;
  wire logic sdaLine;

  // Open-drain lines with pull-ups
  assign sclLine = !(mSclLow || (sclOe && !sclOut));
  assign sdaLine = !(mSdaLow || (sdaOe && !sdaOut));
  // Status bits packed for compact comparison
  assign stat = {portIrqFlag, clockRelease, bufferFull, ackTimingStatus, readWriteStatus, dataAddressStatus,
    updateAddressFlag, sclOe};

  tsh_slave #(.ADDR_RESET(OWN_ADDR)) dut (
    .clk, .sys_rst, .ce, .sclIn(sclLine), .sclOut, .sclOe, .sdaIn(sdaLine), .sdaOut, .sdaOe,
    .tenBitMode(cfg[5]), .addrHoldEnable(cfg[4]), .dataHoldEnable(cfg[3]), .stretchEnable(cfg[2]),
    .startIrqEnable(cfg[1]), .ackDataValue(cfg[0]), .clockReleaseSet(swStrobe[0]), .irqFlagClear(swStrobe[1]),
    .txWrite(swStrobe[2]), .txData(swData), .rxRead(swStrobe[3]), .addrWrite(swStrobe[4]),
    .addrWriteData(swData), .portIrqFlag, .clockRelease, .bufferFull, .ackReceivedStatus, .ackTimingStatus,
    .readWriteStatus, .dataAddressStatus, .startDetected, .stopDetected, .updateAddressFlag, .rxData,
    .slaveAddress
  );

  tsh_bus_master bfm (.sclLine(sclLine), .sdaLine(sdaLine), .sclLow(mSclLow), .sdaLow(mSdaLow), .fails(mFails));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle software strobes: 0 release, 1 irq clear, 2 tx write, 3 rx read, 4 address write
  task automatic sw(input logic [4:0] s, input logic [7:0] d);
    @(negedge clk);
    swStrobe = s;
    swData = d;
    @(negedge clk);
    swStrobe = 5'h00;
    repeat (2) @(negedge clk);
  endtask

  // Configuration levels change at a falling clock edge
  task automatic setCfg(input logic [5:0] c);
    @(negedge clk);
    cfg = c;
  endtask

  // Let the line edge pass the synchroniser, then compare the status bits
  task automatic look(input logic [7:0] exp);
    repeat (12) @(negedge clk);
    check(stat, exp);
  endtask

  task automatic tally_and_finish();
    numErrors += mFails;
    $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    numErrors++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    check(stat, 8'h40);
    check(slaveAddress, OWN_ADDR);
    // Clock enable low: a transmit write must not be taken
    ce = 1'b0;
    sw(5'h04, 8'h00);
    check(stat, 8'h40);
    ce = 1'b1;
    $display("Test clock enable freeze done");
    // Write with address hold, data hold and stretching
    setCfg(6'b011110);
    bfm.busStart();
    repeat (12) @(negedge clk);
    check({5'h00, startDetected, stopDetected, portIrqFlag}, 8'h05);
    sw(5'h02, 8'h00);
    bfm.sendByte(OWN_ADDR);
    look(8'hB1);
    check(rxData, OWN_ADDR);
    sw(5'h0A, 8'h00);
    look(8'h11);
    sw(5'h01, 8'h00);
    bfm.bitXfer(1'b1, ackBit);
    check({7'h00, ackBit}, 8'h00);
    look(8'h81);
    sw(5'h03, 8'h00);
    bfm.sendByte(8'hA5);
    look(8'hB5);
    check(rxData, 8'hA5);
    setCfg(6'b011111);
    sw(5'h0B, 8'h00);
    bfm.bitXfer(1'b1, ackBit);
    check({7'h00, ackBit}, 8'h01);
    sw(5'h03, 8'h00);
    bfm.busStop();
    repeat (12) @(negedge clk);
    check({6'h00, startDetected, stopDetected}, 8'h01);
    $display("Test write with holds done");
    // Read with address hold only
    setCfg(6'b010000);
    sw(5'h02, 8'h00);
    bfm.busStart();
    repeat (12) @(negedge clk);
    check({5'h00, startDetected, stopDetected, portIrqFlag}, 8'h04);
    bfm.sendByte(OWN_ADDR | 8'h01);
    look(8'hB9);
    sw(5'h0B, 8'h00);
    bfm.bitXfer(1'b1, ackBit);
    check({7'h00, ackBit}, 8'h00);
    look(8'h89);
    sw(5'h06, 8'h3C);
    look(8'h29);
    check({7'h00, sdaOe}, 8'h01);
    sw(5'h01, 8'h00);
    bfm.getByte(rdByte);
    check(rdByte, 8'h3C);
    bfm.bitXfer(1'b0, ackBit);
    repeat (12) @(negedge clk);
    check({4'h0, ackReceivedStatus, portIrqFlag, clockRelease, sclOe}, 8'h05);
    sw(5'h06, 8'hC3);
    sw(5'h01, 8'h00);
    bfm.getByte(rdByte);
    check(rdByte, 8'hC3);
    bfm.bitXfer(1'b1, ackBit);
    repeat (12) @(negedge clk);
    check({4'h0, ackReceivedStatus, portIrqFlag, sclOe, sdaOe}, 8'h0C);
    bfm.busStop();
    $display("Test read with address hold done");
    // 10-bit addressing: matching high byte, mismatching then matching low byte
    setCfg(6'b100000);
    sw(5'h12, 8'hF2);
    check(slaveAddress, 8'hF2);
    bfm.busStart();
    bfm.sendByte(8'hF2);
    bfm.bitXfer(1'b1, ackBit);
    check({7'h00, ackBit}, 8'h00);
    look(8'hE3);
    sw(5'h1A, 8'h35);
    look(8'h40);
    bfm.sendByte(8'h36);
    bfm.bitXfer(1'b1, ackBit);
    check({7'h00, ackBit}, 8'h01);
    look(8'hC3);
    sw(5'h12, 8'hF2);
    bfm.busStop();
    bfm.busStart();
    bfm.sendByte(8'hF2);
    bfm.bitXfer(1'b1, ackBit);
    sw(5'h1A, 8'h35);
    bfm.sendByte(8'h35);
    bfm.bitXfer(1'b1, ackBit);
    check({7'h00, ackBit}, 8'h00);
    look(8'hE3);
    sw(5'h1A, 8'hF2);
    bfm.sendByte(8'h81);
    bfm.bitXfer(1'b1, ackBit);
    look(8'hE4);
    check(rxData, 8'h81);
    bfm.busStop();
    $display("Test 10-bit addressing done");
    tally_and_finish();
  end
endmodule // test_tsh_slave
